// ---- inc/ctm_pkg.sv ----
// Package for the compact 10-bit timer with PWM output.
// Assumes one clock domain and a 32-bit AXI4-Lite register bus.
package ctm_pkg;

    // Register byte addresses, one aligned word each.
    localparam logic [4:0] ADDR_CTRL0 = 5'h00;
    localparam logic [4:0] ADDR_CTRL1 = 5'h04;
    localparam logic [4:0] ADDR_CNT_LO = 5'h08;
    localparam logic [4:0] ADDR_CNT_HI = 5'h0C;
    localparam logic [4:0] ADDR_CMPA_LO = 5'h10;
    localparam logic [4:0] ADDR_CMPA_HI = 5'h14;
    localparam logic [4:0] ADDR_FLAGS = 5'h18;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Counter geometry.
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_MAX = 10'h3FF;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [2:0] PER_ZERO = 3'h0;
    localparam int PER_SHIFT = 7;

    // Control register 0 fields.
    localparam int C0_PER_LSB = 0;
    localparam int C0_ON = 3;
    localparam int C0_CLK_LSB = 4;
    localparam int C0_PAUSE = 7;

    // Control register 1 fields.
    localparam int C1_CCLR = 0;
    localparam int C1_SWAP = 1;
    localparam int C1_INV = 2;
    localparam int C1_OLVL = 3;
    localparam int C1_ACT_LSB = 4;
    localparam int C1_MODE_LSB = 6;

    // Flag register bits, write one to clear.
    localparam int FLG_A = 0;
    localparam int FLG_P = 1;

    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Operating modes.
    localparam logic [1:0] MODE_CMP = 2'b00;
    localparam logic [1:0] MODE_PWM = 2'b10;
    localparam logic [1:0] MODE_TMR = 2'b11;

    // Pin actions.
    localparam logic [1:0] ACT_NONE = 2'b00;
    localparam logic [1:0] ACT_LOW = 2'b01;
    localparam logic [1:0] ACT_HIGH = 2'b10;
    localparam logic [1:0] ACT_TOGGLE = 2'b11;
    localparam logic [1:0] ACT_PWM = 2'b10;

    // Counter clock selection codes.
    localparam logic [2:0] CLK_DIV4 = 3'h0;
    localparam logic [2:0] CLK_SYS = 3'h1;
    localparam logic [2:0] CLK_DIV16 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h3;
    localparam logic [2:0] CLK_EXT_RISE = 3'h6;
    localparam logic [2:0] CLK_EXT_FALL = 3'h7;

    // Decoded control fields.
    typedef struct packed {
        logic pause;
        logic [2:0] clk_sel;
        logic counter_on_bit;
        logic [2:0] period_value;
    } ctrl0_t;

    typedef struct packed {
        logic mode_field_hi;
        logic mode_field_lo;
        logic pin_action_hi;
        logic pin_action_lo;
        logic output_level_bit;
        logic invert_bit;
        logic period_duty_swap;
        logic clear_select;
    } ctrl1_t;

endpackage

// ---- sim/ctm_timer_checker.sv ----
// Concurrent checks on the timer's register bus and its output pin.
// Assumes it is bound to ctm_timer and sees only that module's ports.
`timescale 1ns/1ns

module ctm_timer_checker
    import ctm_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels.
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels.
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Output pin.
    input wire logic timer_out,
    input wire logic timer_out_oe_n
);
    // Handshake decodes; the shadow registers see only byte-lane writes.
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    wire wr_byte = wr_take && s_axi_wstrb[0];
    wire rd_take = s_axi_arvalid && s_axi_arready;
    logic [1:0] mode_r;
    logic on_r;
    logic olvl_r;

    // Shadow of the mode, output level and counter-on bits.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r <= MODE_CMP;
            olvl_r <= 1'b0;
            on_r <= 1'b0;
        end
        else if (wr_byte && s_axi_awaddr == ADDR_CTRL1)
        begin
            mode_r <= s_axi_wdata[7:6];
            olvl_r <= s_axi_wdata[3];
        end
        else if (wr_byte && s_axi_awaddr == ADDR_CTRL0)
            on_r <= s_axi_wdata[3];
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Counter switched on from off while in compare mode.
    sequence on_rise_seq;
        wr_byte && s_axi_awaddr == ADDR_CTRL0 && s_axi_wdata[3] && !on_r
            && mode_r == MODE_CMP;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Bus timing.
    b_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response did not follow the write");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    r_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data did not follow the address");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    w_block_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    unmapped_rd_a: assert property (rd_take && s_axi_araddr > ADDR_FLAGS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");

    ////////////////////////////////////////////////////////////////////////
    // Register contents and pin.
    high_bits_a: assert property (
        rd_take && (s_axi_araddr == ADDR_CNT_HI
        || s_axi_araddr == ADDR_CMPA_HI) |=> s_axi_rdata[31:2] == '0)
        else $error("high byte upper bits not zero");
    oe_mode_a: assert property (
        timer_out_oe_n == ($past(mode_r) == MODE_TMR))
        else $error("pin enable does not follow timer mode");
    pin_restart_a: assert property (
        on_rise_seq |-> ##3 timer_out == olvl_r)
        else $error("pin not restored to initial level");
endmodule // ctm_timer_checker

bind ctm_timer ctm_timer_checker u_ctm_timer_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_out(timer_out), .timer_out_oe_n(timer_out_oe_n)
);

// ---- sim/tb.sv ----
// Self-checking bench for the timer through its AXI4-Lite registers.
// Assumes the counter clock select code 1 ticks once per aclk cycle.
`timescale 1ns/1ns

module tb
    import ctm_pkg::*;
;
    // Bench-driven inputs.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    // Design outputs and results.
    logic awready, wready, bvalid, arready, rvalid, timer_out, oe_n;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d, c1, c2;
    int bad_count = 0;
    int total_checks = 0;
    int hi;
    // PWM rows: control 1, compare A, high cycles in 512, flags.
    logic [7:0] pc [8] = '{8'hA8, 8'hA9, 8'hAC, 8'hA0, 8'hAA, 8'hA8, 8'h98,
        8'h88};
    logic [9:0] pa [8] = '{10'h020, 10'h020, 10'h020, 10'h020, 10'h100,
        10'h0C8, 10'h020, 10'h020};
    int ph [8] = '{128, 128, 384, 384, 256, 512, 512, 0};
    logic [7:0] pf [8] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h02, 8'h03,
        8'h03};

    ctm_timer u_ctm_timer (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_clk_pin(1'b0), .timer_out(timer_out),
        .timer_out_oe_n(oe_n)
    );

    // Clock of 4 ns.
    always #2 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////
    // Compare tasks; case inequality so that unknowns never match.
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        check_val(32'(got), 32'(exp));
    endtask

    // Write: readies and response are sampled mid-cycle, changes follow
    // the rising edge, so each channel drops only after its own handshake.
    task automatic axi_wr(input logic [4:0] a, input logic [7:0] v);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] br;
        int n;
        b_hs = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hs && n < 64)
        begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = (bvalid === 1'b1);
            br = bresp;
            n++;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
        end
        check_val(32'(b_hs), 32'h0000_0001);
        // Only the aligned words up to the flag register answer OKAY.
        check_resp(br, (a <= ADDR_FLAGS && a[1:0] == 2'b00) ? RESP_OKAY
            : RESP_SLVERR);
    endtask

    // Read: data and response are sampled mid-cycle, in the cycle that completes it.
    task automatic axi_rd(input logic [4:0] a, output logic [31:0] dv,
        output logic [1:0] rv);
        logic ar_hs, got;
        int n;
        got = 1'b0;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got && n < 64)
        begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            got = (rvalid === 1'b1);
            dv = rdata;
            rv = rresp;
            n++;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (got) rready <= 1'b0;
        end
        check_val(32'(got), 32'h0000_0001);
    endtask

    // Read with an OKAY response expected.
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        axi_rd(a, d, r);
        check_resp(r, RESP_OKAY);
        check_val(d, exp);
    endtask

    // Counter value from its two byte registers.
    task automatic rd_cnt(output logic [31:0] c);
        logic [31:0] lo;
        axi_rd(ADDR_CNT_LO, lo, r);
        axi_rd(ADDR_CNT_HI, c, r);
        c = {c[23:0], lo[7:0]};
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(5'(4 * i), 32'h0000_0000);
        axi_rd(5'h1C, d, r);
        check_resp(r, RESP_SLVERR);
        check_val(d, 32'h0000_0000);
        axi_wr(ADDR_CNT_LO, 8'h5A);
        axi_wr(5'h1C, 8'h5A);
        rd_chk(ADDR_CNT_LO, 32'h0000_0000);
        axi_wr(ADDR_CMPA_LO, 8'hC8);
        axi_wr(ADDR_CMPA_HI, 8'hFC);
        rd_chk(ADDR_CMPA_HI, 32'h0000_0000);
        rd_chk(ADDR_CMPA_LO, 32'h0000_00C8);
        // Compare mode: clear on A at 200, toggle, initial high, P at 128.
        axi_wr(ADDR_CTRL1, 8'h39);
        axi_wr(ADDR_CTRL0, 8'h19);
        idle(100);
        check_val(32'(timer_out), 32'h0000_0001);
        idle(150);
        check_val(32'(timer_out), 32'h0000_0000);
        axi_wr(ADDR_CTRL0, 8'h11);
        rd_cnt(c1);
        idle(20);
        rd_cnt(c2);
        check_val(c2, c1);
        check_val(32'(c1 < 200), 32'h0000_0001);
        rd_chk(ADDR_FLAGS, 32'h0000_0001);
        axi_wr(ADDR_CTRL0, 8'h19);
        idle(4);
        check_val(32'(timer_out), 32'h0000_0001);
        rd_cnt(c1);
        check_val(32'(c1 > 0 && c1 < 30), 32'h0000_0001);
        // Timer mode: clear on P at 128, A match at 64, pin released.
        axi_wr(ADDR_CTRL0, 8'h11);
        axi_wr(ADDR_FLAGS, 8'h03);
        axi_wr(ADDR_CMPA_LO, 8'h40);
        axi_wr(ADDR_CMPA_HI, 8'h00);
        axi_wr(ADDR_CTRL1, 8'hC0);
        axi_wr(ADDR_CTRL0, 8'h19);
        idle(300);
        rd_chk(ADDR_FLAGS, 32'h0000_0003);
        rd_cnt(c1);
        check_val(32'(c1 < 128), 32'h0000_0001);
        check_val(32'(oe_n), 32'h0000_0001);
        // Compare A of zero with clear on A: runs past the top count.
        axi_wr(ADDR_CTRL0, 8'h11);
        axi_wr(ADDR_CMPA_LO, 8'h00);
        axi_wr(ADDR_CTRL1, 8'h01);
        axi_wr(ADDR_FLAGS, 8'h03);
        axi_wr(ADDR_CTRL0, 8'h19);
        idle(1100);
        rd_chk(ADDR_FLAGS, 32'h0000_0000);
        rd_cnt(c1);
        check_val(32'(c1 < 150), 32'h0000_0001);
        check_val(32'(timer_out), 32'h0000_0000);
        // Quarter-rate tick, then the pause bit holds the count.
        axi_wr(ADDR_CTRL0, 8'h11);
        axi_wr(ADDR_CTRL0, 8'h09);
        idle(200);
        axi_wr(ADDR_CTRL0, 8'h89);
        rd_cnt(c1);
        idle(20);
        rd_cnt(c2);
        check_val(c2, c1);
        check_val(32'(c1 > 40 && c1 < 70), 32'h0000_0001);
        // PWM rows, P of 1 gives 128 clocks; 512 samples span whole periods.
        for (int i = 0; i < 8; i++)
        begin
            axi_wr(ADDR_CTRL0, 8'h11);
            axi_wr(ADDR_CMPA_LO, pa[i][7:0]);
            axi_wr(ADDR_CMPA_HI, {6'h00, pa[i][9:8]});
            axi_wr(ADDR_CTRL1, pc[i]);
            axi_wr(ADDR_FLAGS, 8'h03);
            axi_wr(ADDR_CTRL0, 8'h19);
            idle(20);
            hi = 0;
            repeat (512)
            begin
                @(negedge aclk);
                if (timer_out === 1'b1) hi++;
            end
            check_val(32'(hi), 32'(ph[i]));
            rd_chk(ADDR_FLAGS, 32'(pf[i]));
        end
        wrap_up();
    end

    // Watchdog, well beyond the expected length of the run.
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        wrap_up();
    end
endmodule // tb

// ---- verilog/ctm_timer.sv ----
// Compact 10-bit up-counting timer with comparators A and P and one pin.
// Assumes AXI4-Lite master on aclk, external pins asynchronous to aclk.
//
// Functional notes
// RQ1: Counter readable as low byte and two-bit high byte, upper bits zero.
// RQ2: Compare A is ten bits over two bytes, resetting to zero.
// RQ3: Mode 00 compare output, 11 timer, 10 PWM.
// RQ4: Clear-select low clears on P match or overflow; both flags raised.
// RQ5: Clear-select high clears on A match; P flag never raised.
// RQ6: Clear-select high with A zero overflows at 3FF without A flag.
// RQ7: Compare mode changes the pin only on an A flag; the code also sets it on a counter-on rising edge (RQ9).
// RQ8: A match drives pin high, low, toggles, or none per pin action.
// RQ9: Counter-on rising edge restores pin to the output level bit; the code does this in compare mode only.
// RQ10: Timer mode counts and flags like compare mode, pin not driven.
// RQ11: PWM ignores clear-select; period comparator clear starts each period.
// RQ12: Swap low: P times 128 is period, 1024 when zero; A is duty.
// RQ13: Swap high: A clears counter as period; P times 128 is duty.
// RQ14: Duty at or above period gives continuous active output.
// RQ15: PWM raises A flag on A match and P flag on P match.
// RQ16: Output level bit selects active level; invert bit reverses polarity.
// RQ17: PWM counting and flags continue while pin is forced.
// RQ18: Counter-on rising edge zeroes counter; falling edge keeps count.
// RQ19: Period value compares only with counter bits 9 to 7.
// RQ20: Compare pin action: 00 none, 01 low, 10 high, 11 toggle.
// RQ21: PWM pin action: 00 inactive, 01 active, 10 waveform, 11 undefined.
// RQ22: Counter increments per selected tick while on and not paused.
`timescale 1ns/1ns

module ctm_timer
    import ctm_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [4:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [4:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External counter clock pin.
    input wire logic ext_clk_pin,
    // Timer output pin and its enable, enable low while driving.
    output logic timer_out,
    output logic timer_out_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    ctrl0_t c0_r;
    ctrl1_t c1_r;
    logic [9:0] compare_a_value_r;
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic flag_a_r;
    logic flag_p_r;
    logic pin_r;
    logic pin_nxt;
    logic on_d_r;
    logic [5:0] pre_r;
    logic [2:0] ext_sync_r;
    logic ext_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data latched in either order.
    logic aw_held_r;
    logic w_held_r;
    logic [4:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    wire do_write = aw_held_r && w_held_r && !bvalid_r;
    wire wr_hit = (aw_addr_r == ADDR_CTRL0) || (aw_addr_r == ADDR_CTRL1)
        || (aw_addr_r == ADDR_CMPA_LO) || (aw_addr_r == ADDR_CMPA_HI)
        || (aw_addr_r == ADDR_FLAGS) || (aw_addr_r == ADDR_CNT_LO)
        || (aw_addr_r == ADDR_CNT_HI);
    wire wr_lane0 = do_write && w_strb_r[0];

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Hold channels until the response is accepted.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 5'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_r)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data.
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] rd_byte;
    logic rd_hit;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Read decode; narrow registers sit in the low bits.
    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_CTRL0: rd_byte = c0_r;
            ADDR_CTRL1: rd_byte = c1_r;
            ADDR_CNT_LO: rd_byte = cnt_r[7:0]; // RQ1
            ADDR_CNT_HI: rd_byte = {6'h00, cnt_r[9:8]}; // RQ1
            ADDR_CMPA_LO: rd_byte = compare_a_value_r[7:0]; // RQ2
            ADDR_CMPA_HI: rd_byte = {6'h00, compare_a_value_r[9:8]}; // RQ2
            ADDR_FLAGS: rd_byte = {6'h00, flag_p_r, flag_a_r};
            default:
            begin
                rd_byte = BYTE_ZERO;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Capture read data when the address is taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter tick source: prescaler or synchronised external pin.
    wire ext_rise = ext_sync_r[1] && ext_sync_r[2] && !ext_prev_r;
    wire ext_fall = !ext_sync_r[1] && !ext_sync_r[2] && ext_prev_r;
    logic tick;

    always_comb
    begin
        case (c0_r.clk_sel)
            CLK_DIV4: tick = (pre_r[1:0] == 2'h3);
            CLK_SYS: tick = 1'b1;
            CLK_DIV16: tick = (pre_r[3:0] == 4'hF);
            CLK_DIV64: tick = (pre_r == 6'h3F);
            CLK_EXT_RISE: tick = ext_rise;
            CLK_EXT_FALL: tick = ext_fall;
            default: tick = (pre_r == 6'h3F);
        endcase
    end

    // Prescaler and three-stage pin synchroniser; change when 2 and 3 agree.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pre_r <= 6'h00;
            ext_sync_r <= 3'h0;
            ext_prev_r <= 1'b0;
        end
        else
        begin
            pre_r <= pre_r + 6'h01;
            ext_sync_r <= {ext_sync_r[1:0], ext_clk_pin};
            if (ext_sync_r[1] == ext_sync_r[2])
                ext_prev_r <= ext_sync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparators and clear logic.
    wire [1:0] mode = {c1_r.mode_field_hi, c1_r.mode_field_lo};
    wire [1:0] act = {c1_r.pin_action_hi, c1_r.pin_action_lo};
    wire is_pwm = (mode == MODE_PWM); // RQ3
    wire is_cmp = (mode == MODE_CMP); // RQ3
    wire [2:0] per = c0_r.period_value;
    wire on_rise = c0_r.counter_on_bit && !on_d_r;
    wire run = c0_r.counter_on_bit && !c0_r.pause && tick; // RQ22
    wire [9:0] cnt_inc = cnt_r + 10'h001;
    // Period value meets only the top three counter bits.
    wire match_p = (per != PER_ZERO)
        && (cnt_inc[9:PER_SHIFT] == per)
        && (cnt_inc[PER_SHIFT-1:0] == 7'h00); // RQ19
    wire ovf = (cnt_r == CNT_MAX);
    wire match_a = (compare_a_value_r != CNT_ZERO)
        && (cnt_inc == compare_a_value_r); // RQ6
    // Clear source: PWM follows the swap bit, else the clear-select bit.
    wire clr_on_a = is_pwm ? c1_r.period_duty_swap
        : c1_r.clear_select; // RQ11 RQ13
    wire clr_p = !clr_on_a && (match_p || (per == PER_ZERO && ovf)); // RQ4
    wire clr_a = clr_on_a && match_a; // RQ5
    wire ev_a = run && match_a; // RQ15
    wire ev_p = run && match_p && (is_pwm || !c1_r.clear_select); // RQ5
    // P span for PWM, period or duty per the swap bit; a zero period value means 1024.
    wire [10:0] p_span = (per == PER_ZERO) ? 11'h400
        : {per, 8'h00} >> 1; // RQ12
    wire [10:0] a_span = {1'b0, compare_a_value_r};
    wire [10:0] duty = c1_r.period_duty_swap ? p_span : a_span; // RQ13
    wire [10:0] period = c1_r.period_duty_swap ? a_span : p_span;
    wire full_duty = (duty >= period); // RQ14
    wire active = full_duty || ({1'b0, cnt_r} < duty);

    // Counter next value.
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (on_rise)
            cnt_nxt = CNT_ZERO; // RQ18
        else if (run && (clr_a || clr_p))
            cnt_nxt = CNT_ZERO; // RQ4 RQ11
        else if (run)
            cnt_nxt = cnt_inc; // RQ22
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pin next value.
    wire pwm_lvl = (c1_r.output_level_bit ? active : !active)
        ^ c1_r.invert_bit; // RQ16
    wire act_lvl = c1_r.output_level_bit ^ c1_r.invert_bit;

    always_comb
    begin
        pin_nxt = pin_r;
        if (is_pwm)
        begin
            case (act) // RQ21 RQ17
                ACT_NONE: pin_nxt = !act_lvl;
                ACT_LOW: pin_nxt = act_lvl;
                ACT_PWM: pin_nxt = pwm_lvl;
                default: pin_nxt = pin_r;
            endcase
        end
        else if (on_rise && is_cmp)
            pin_nxt = c1_r.output_level_bit; // RQ9
        else if (is_cmp && ev_a)
        begin
            case (act) // RQ7 RQ8 RQ20
                ACT_LOW: pin_nxt = 1'b0;
                ACT_HIGH: pin_nxt = 1'b1;
                ACT_TOGGLE: pin_nxt = !pin_r;
                default: pin_nxt = pin_r;
            endcase
        end
    end

    // Timer mode releases the pin for other uses.
    assign timer_out = pin_r;
    assign timer_out_oe_n = (mode == MODE_TMR); // RQ10

    ////////////////////////////////////////////////////////////////////////
    // Core state and software-written registers; flag set beats clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            c0_r <= '0;
            c1_r <= '0;
            compare_a_value_r <= CNT_ZERO; // RQ2
            cnt_r <= CNT_ZERO;
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
            pin_r <= 1'b0;
            on_d_r <= 1'b0;
        end
        else
        begin
            on_d_r <= c0_r.counter_on_bit;
            cnt_r <= cnt_nxt;
            pin_r <= pin_nxt;
            if (wr_lane0 && aw_addr_r == ADDR_CTRL0)
                c0_r <= w_data_r[7:0];
            if (wr_lane0 && aw_addr_r == ADDR_CTRL1)
                c1_r <= w_data_r[7:0];
            if (wr_lane0 && aw_addr_r == ADDR_CMPA_LO)
                compare_a_value_r[7:0] <= w_data_r[7:0];
            if (wr_lane0 && aw_addr_r == ADDR_CMPA_HI)
                compare_a_value_r[9:8] <= w_data_r[1:0];
            if (ev_a)
                flag_a_r <= 1'b1; // RQ4 RQ15
            else if (wr_lane0 && aw_addr_r == ADDR_FLAGS && w_data_r[FLG_A])
                flag_a_r <= 1'b0;
            if (ev_p)
                flag_p_r <= 1'b1; // RQ4 RQ15
            else if (wr_lane0 && aw_addr_r == ADDR_FLAGS && w_data_r[FLG_P])
                flag_p_r <= 1'b0;
        end
    end

endmodule // ctm_timer
